// ==== design/serial_unit_defines.svh ====
`ifndef SERIAL_UNIT_DEFINES_SVH
`define SERIAL_UNIT_DEFINES_SVH
`define SU_DATA_W 8
`define SU_FIFO_DEPTH 16
`define SU_BIT_CNT_W 16
`define SU_GAP_CLKS 16'h0002
`define SU_PAR_NONE 2'h0
`define SU_PAR_ZERO 2'h1
`define SU_PAR_ODD 2'h2
`define SU_PAR_EVEN 2'h3
`define SU_LINE_IDLE 1'h1
`define SU_LAST_BIT8 3'h7
`define SU_LAST_BIT7 3'h6
`endif

// ==== design/serial_unit_pkg.sv ====
`include "serial_unit_defines.svh"
package serial_unit_pkg;
	typedef struct packed {
		logic unit_power_bit;
		logic tx_enable_bit;
		logic rx_enable_bit;
		logic parity_select_hi;
		logic parity_select_lo;
		logic char_length_bit;
		logic stop_length_bit;
		logic rx_error_irq_mode_bit;
	} mode_reg_t;
	typedef struct packed {
		logic tx_buffer_full_flag;
		logic tx_shift_busy;
	} tx_status_t;
	typedef struct packed {
		logic [`SU_DATA_W-1:0] data;
		logic parity_err;
		logic framing_err;
	} rx_result_t;
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h2,
		TX_PAR = 3'h3,
		TX_STOP = 3'h4,
		TX_GAP = 3'h5
	} tx_state_t;
	typedef enum logic [2:0] {
		RX_IDLE = 3'h0,
		RX_START = 3'h1,
		RX_DATA = 3'h2,
		RX_PAR = 3'h3,
		RX_STOP = 3'h4
	} rx_state_t;
	typedef struct packed {
		tx_state_t tx_st;
		logic [`SU_BIT_CNT_W-1:0] tx_cnt;
		logic [2:0] tx_bit;
		logic [`SU_DATA_W-1:0] tx_sh;
		logic tx_pbit;
		logic tx_stop2;
		logic tx_pin;
		logic tx_busy;
		logic tx_done;
		rx_state_t rx_st;
		logic [`SU_BIT_CNT_W-1:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [`SU_DATA_W-1:0] rx_sh;
		logic rx_pbit;
		rx_result_t rx_res;
		logic rx_done;
		logic rx_err;
	} su_state_t;
endpackage : serial_unit_pkg

// ==== design/tx_fifo.sv ====
`timescale 1ns/100ps
module tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic flush,
	input wire logic in_valid,
	input wire logic [WIDTH-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data,
	input wire logic out_ready,
	output logic full
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] CMAX = CW'(DEPTH);
	localparam logic [AW-1:0] AMAX = AW'(DEPTH - 1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [CW-1:0] cnt;
		logic full;
		logic ready;
	} fifo_state_t;
	fifo_state_t s_ff;
	fifo_state_t nxt_s;
	logic push;
	logic pop;

	function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
		return (p == AMAX) ? '0 : p + 1'b1;
	endfunction : wrap_inc

	assign push = in_valid & s_ff.ready;
	assign pop = out_ready & (s_ff.cnt != '0);
	assign out_valid = s_ff.cnt != '0;
	assign out_data = s_ff.mem[s_ff.rp];
	assign in_ready = s_ff.ready;
	assign full = s_ff.full;

	always_comb begin
		nxt_s = s_ff;
		if (flush) begin
			nxt_s.wp = '0;
			nxt_s.rp = '0;
			nxt_s.cnt = '0;
		end else begin
			if (push) begin
				nxt_s.mem[s_ff.wp] = in_data;
				nxt_s.wp = wrap_inc(s_ff.wp);
			end
			if (pop) begin
				nxt_s.rp = wrap_inc(s_ff.rp);
			end
			if (push && !pop) begin
				nxt_s.cnt = s_ff.cnt + 1'b1;
			end else if (pop && !push) begin
				nxt_s.cnt = s_ff.cnt - 1'b1;
			end
		end
		nxt_s.full = nxt_s.cnt == CMAX;
		nxt_s.ready = nxt_s.cnt != CMAX;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.ready <= 1'b1;
		end else begin
			s_ff <= nxt_s;
		end
	end

	AST_FULL_REFUSES: assert property (@(posedge sys_clk) disable iff (rst)
		(s_ff.full && in_valid && !pop && !flush) |=> $stable(s_ff.wp))
		else $error("write taken while buffer full");
	AST_COUNT_UP: assert property (@(posedge sys_clk) disable iff (rst)
		(push && !pop && !flush) |=> s_ff.cnt == $past(s_ff.cnt) + 1'b1)
		else $error("fifo count did not advance on push");
endmodule : tx_fifo

// ==== design/serial_unit.sv ====
`timescale 1ns/100ps
module serial_unit
	import serial_unit_pkg::*;
#(
	parameter int FIFO_DEPTH = `SU_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire mode_reg_t operation_mode_reg,
	input wire logic [`SU_BIT_CNT_W-1:0] bit_period,
	input wire logic tx_wr_valid,
	input wire logic [`SU_DATA_W-1:0] tx_buffer,
	output logic tx_wr_ready,
	output tx_status_t tx_status_reg,
	output logic tx_done,
	output logic serial_tx_pin,
	input wire logic serial_rx_pin,
	output rx_result_t rx_result,
	output logic rx_done,
	output logic rx_err
);
	localparam int CW = `SU_BIT_CNT_W;
	su_state_t s_ff;
	su_state_t nxt_s;
	mode_reg_t m;
	logic tx_en;
	logic rx_en;
	logic pop;
	logic fifo_valid;
	logic fifo_full;
	logic [`SU_DATA_W-1:0] fifo_data;
	logic [1:0] psel;
	logic [CW-1:0] reload;

	function automatic logic cnt_end(input logic [CW-1:0] c);
		return c == '0;
	endfunction : cnt_end

	function automatic logic data_par(input logic [`SU_DATA_W-1:0] d,
		input logic cl);
		return cl ? ^d : ^d[`SU_DATA_W-2:0];
	endfunction : data_par

	function automatic logic [2:0] last_bit(input logic cl);
		return cl ? `SU_LAST_BIT8 : `SU_LAST_BIT7;
	endfunction : last_bit

	function automatic logic par_out(input logic [1:0] ps, input logic x);
		case (ps)
			`SU_PAR_ODD: par_out = ~x;
			`SU_PAR_EVEN: par_out = x;
			default: par_out = 1'b0;
		endcase
	endfunction : par_out

	assign m = operation_mode_reg;
	assign tx_en = m.unit_power_bit & m.tx_enable_bit;
	assign rx_en = m.unit_power_bit & m.rx_enable_bit;
	assign psel = {m.parity_select_hi, m.parity_select_lo};
	assign reload = bit_period - 1'b1;
	assign pop = fifo_valid & tx_en & ((s_ff.tx_st == TX_IDLE) |
		((s_ff.tx_st == TX_GAP) & cnt_end(s_ff.tx_cnt)));

	// power off drains the buffer so a restart begins clean
	tx_fifo #(
		.WIDTH(`SU_DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.flush(~m.unit_power_bit),
		.in_valid(tx_wr_valid),
		.in_data(tx_buffer),
		.in_ready(tx_wr_ready),
		.out_valid(fifo_valid),
		.out_data(fifo_data),
		.out_ready(pop),
		.full(fifo_full)
	);

	always_comb begin
		nxt_s = s_ff;
		nxt_s.tx_done = 1'b0;
		nxt_s.rx_done = 1'b0;
		nxt_s.rx_err = 1'b0;
		if (s_ff.tx_st != TX_IDLE) begin
			nxt_s.tx_cnt = s_ff.tx_cnt - 1'b1;
		end
		if (s_ff.rx_st != RX_IDLE) begin
			nxt_s.rx_cnt = s_ff.rx_cnt - 1'b1;
		end
		// transmit engine
		case (s_ff.tx_st)
			TX_IDLE: nxt_s.tx_pin = `SU_LINE_IDLE;
			TX_START: begin
				if (cnt_end(s_ff.tx_cnt)) begin
					nxt_s.tx_st = TX_DATA;
					nxt_s.tx_bit = 3'h0;
					nxt_s.tx_pin = s_ff.tx_sh[0];
					nxt_s.tx_cnt = reload;
				end
			end
			TX_DATA: begin
				if (cnt_end(s_ff.tx_cnt)) begin
					nxt_s.tx_cnt = reload;
					if (s_ff.tx_bit == last_bit(m.char_length_bit)) begin
						nxt_s.tx_stop2 = m.stop_length_bit;
						if (psel == `SU_PAR_NONE) begin
							nxt_s.tx_st = TX_STOP;
							nxt_s.tx_pin = `SU_LINE_IDLE;
						end else begin
							nxt_s.tx_st = TX_PAR;
							nxt_s.tx_pin = s_ff.tx_pbit;
						end
					end else begin
						nxt_s.tx_bit = s_ff.tx_bit + 1'b1;
						nxt_s.tx_sh = s_ff.tx_sh >> 1;
						nxt_s.tx_pin = s_ff.tx_sh[1];
					end
				end
			end
			TX_PAR: begin
				if (cnt_end(s_ff.tx_cnt)) begin
					nxt_s.tx_st = TX_STOP;
					nxt_s.tx_pin = `SU_LINE_IDLE;
					nxt_s.tx_cnt = reload;
				end
			end
			TX_STOP: begin
				if (cnt_end(s_ff.tx_cnt)) begin
					nxt_s.tx_cnt = reload;
					if (s_ff.tx_stop2) begin
						nxt_s.tx_stop2 = 1'b0;
					end else begin
						nxt_s.tx_done = 1'b1;
						if (fifo_valid && tx_en) begin
							nxt_s.tx_st = TX_GAP;
							nxt_s.tx_cnt = `SU_GAP_CLKS - 1'b1;
						end else begin
							nxt_s.tx_st = TX_IDLE;
							nxt_s.tx_busy = 1'b0;
						end
					end
				end
			end
			TX_GAP: begin
				if (cnt_end(s_ff.tx_cnt) && !fifo_valid) begin
					nxt_s.tx_st = TX_IDLE;
					nxt_s.tx_busy = 1'b0;
				end
			end
			default: nxt_s.tx_st = TX_IDLE;
		endcase
		if (pop) begin
			nxt_s.tx_st = TX_START;
			nxt_s.tx_sh = fifo_data;
			nxt_s.tx_pbit = par_out(psel,
				data_par(fifo_data, m.char_length_bit));
			nxt_s.tx_cnt = reload;
			nxt_s.tx_pin = 1'b0;
			nxt_s.tx_busy = 1'b1;
		end
		if (!tx_en) begin
			nxt_s.tx_st = TX_IDLE;
			nxt_s.tx_pin = `SU_LINE_IDLE;
			nxt_s.tx_busy = 1'b0;
		end
		// receive engine
		case (s_ff.rx_st)
			RX_IDLE: begin
				if (rx_en && !serial_rx_pin) begin
					nxt_s.rx_st = RX_START;
					nxt_s.rx_cnt = bit_period >> 1;
				end
			end
			RX_START: begin
				if (cnt_end(s_ff.rx_cnt)) begin
					nxt_s.rx_st = serial_rx_pin ? RX_IDLE : RX_DATA;
					nxt_s.rx_bit = 3'h0;
					nxt_s.rx_cnt = reload;
				end
			end
			RX_DATA: begin
				if (cnt_end(s_ff.rx_cnt)) begin
					nxt_s.rx_cnt = reload;
					nxt_s.rx_sh = {serial_rx_pin, s_ff.rx_sh[`SU_DATA_W-1:1]};
					nxt_s.rx_bit = s_ff.rx_bit + 1'b1;
					if (s_ff.rx_bit == last_bit(m.char_length_bit)) begin
						nxt_s.rx_st = (psel == `SU_PAR_NONE) ? RX_STOP : RX_PAR;
					end
				end
			end
			RX_PAR: begin
				if (cnt_end(s_ff.rx_cnt)) begin
					nxt_s.rx_pbit = serial_rx_pin;
					nxt_s.rx_st = RX_STOP;
					nxt_s.rx_cnt = reload;
				end
			end
			RX_STOP: begin
				if (cnt_end(s_ff.rx_cnt)) begin
					nxt_s.rx_st = RX_IDLE;
					nxt_s.rx_res.data = m.char_length_bit ? s_ff.rx_sh :
						s_ff.rx_sh >> 1;
					nxt_s.rx_res.framing_err = ~serial_rx_pin;
					nxt_s.rx_res.parity_err = (psel[1]) &&
						(par_out(psel, data_par(nxt_s.rx_res.data,
						m.char_length_bit)) != s_ff.rx_pbit);
					nxt_s.rx_err = nxt_s.rx_res.framing_err |
						nxt_s.rx_res.parity_err;
					nxt_s.rx_done = ~nxt_s.rx_err | m.rx_error_irq_mode_bit;
				end
			end
			default: nxt_s.rx_st = RX_IDLE;
		endcase
		if (!rx_en) begin
			nxt_s.rx_st = RX_IDLE;
		end
		if (!m.unit_power_bit) begin
			nxt_s = '0;
			nxt_s.tx_pin = `SU_LINE_IDLE;
			nxt_s.rx_res = s_ff.rx_res;
		end
	end

	// no enable, stopped clock freezes all
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_ff <= '0;
			s_ff.tx_pin <= `SU_LINE_IDLE;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign serial_tx_pin = s_ff.tx_pin;
	assign tx_status_reg.tx_buffer_full_flag = fifo_full;
	assign tx_status_reg.tx_shift_busy = s_ff.tx_busy;
	assign tx_done = s_ff.tx_done;
	assign rx_result = s_ff.rx_res;
	assign rx_done = s_ff.rx_done;
	assign rx_err = s_ff.rx_err;

	sequence gap_then_start;
		(s_ff.tx_st == TX_GAP) [*2] ##1 (s_ff.tx_st == TX_START);
	endsequence

	AST_GAP_TWO: assert property (@(posedge sys_clk)
		disable iff (rst || !tx_en)
		(s_ff.tx_st == TX_STOP && cnt_end(s_ff.tx_cnt) && !s_ff.tx_stop2
		&& fifo_valid) |=> gap_then_start)
		else $error("inter-frame gap is not two clocks");
	AST_START_LOW: assert property (@(posedge sys_clk)
		disable iff (rst || !tx_en)
		pop |=> !serial_tx_pin && s_ff.tx_busy)
		else $error("start bit not driven after pop");
	AST_PWR_OFF: assert property (@(posedge sys_clk) disable iff (rst)
		!m.unit_power_bit |=> serial_tx_pin && s_ff.tx_st == TX_IDLE
		&& s_ff.rx_st == RX_IDLE)
		else $error("engines not reset with power off");
	AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
		s_ff.tx_st == TX_IDLE |-> serial_tx_pin)
		else $error("idle transmit line not high");
	AST_LOW_STARTS: assert property (@(posedge sys_clk) disable iff (rst)
		(rx_en && s_ff.rx_st == RX_IDLE && !serial_rx_pin)
		|=> s_ff.rx_st == RX_START)
		else $error("low line at enable did not start reception");
	AST_RX_RETIME: assert property (@(posedge sys_clk) disable iff (rst)
		(rx_en && s_ff.rx_st == RX_IDLE && !serial_rx_pin)
		|=> s_ff.rx_cnt == ($past(bit_period) >> 1))
		else $error("bit timing not restarted at start bit");
	AST_ONE_STOP: assert property (@(posedge sys_clk)
		disable iff (rst || !rx_en)
		(s_ff.rx_st == RX_STOP && cnt_end(s_ff.rx_cnt))
		|=> s_ff.rx_st == RX_IDLE && (rx_done || rx_err))
		else $error("receiver did not finish after one stop bit");
	AST_TX_RUNS: assert property (@(posedge sys_clk)
		disable iff (rst || !tx_en)
		(s_ff.tx_st == TX_DATA && !cnt_end(s_ff.tx_cnt))
		|=> s_ff.tx_st == TX_DATA && $stable(serial_tx_pin))
		else $error("transmit bit cut short");
endmodule : serial_unit

// ==== verif/remote_node.sv ====
`timescale 1ns/100ps
module remote_node #(
	parameter int BP = 8
) (
	input wire logic sys_clk,
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] got_q[$];
	int start_q[$];
	int cyc = 0;
	logic [7:0] sh;
	initial line_out = 1'h1;
	always @(posedge sys_clk) cyc <= cyc + 1;
	// decoder samples mid-bit, one stop bit, lsb first
	initial forever begin
		@(posedge sys_clk);
		#1;
		if (line_in === 1'h0) begin
			start_q.push_back(cyc);
			repeat (BP / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BP) @(posedge sys_clk);
				sh[i] = line_in;
			end
			repeat (BP) @(posedge sys_clk);
			got_q.push_back(sh);
		end
	end
	task automatic send_frame(input logic [7:0] d, input logic par_on,
		input logic pbit);
		logic [10:0] f;
		int n;
		f = par_on ? {1'h1, pbit, d, 1'h0} : {2'h3, d, 1'h0};
		n = par_on ? 11 : 10;
		@(posedge sys_clk);
		#1;
		for (int i = 0; i < n; i++) begin
			line_out = f[i];
			repeat (BP) @(posedge sys_clk);
			#1;
		end
	endtask : send_frame
endmodule : remote_node

// ==== verif/async_serial_unit_six_control_bench.sv ====
`timescale 1ns/100ps
module async_serial_unit_six_control_bench;
	import serial_unit_pkg::*;
	localparam int BP = 8;
	logic sys_clk = 1'h0;
	logic clk_run = 1'h1;
	logic rst = 1'h1;
	mode_reg_t md = 8'h00;
	logic tx_wr_valid = 1'h0;
	logic [7:0] tx_buffer = 8'h00;
	logic tx_wr_ready, tx_done, serial_tx_pin, rx_line, rx_done, rx_err;
	logic seen_done, seen_err, pin_hold, pb;
	logic [1:0] st_hold;
	tx_status_t tx_status_reg;
	rx_result_t rx_result;
	int err_total = 0;
	int compares = 0;
	int cycles = 0;
	int n_done = 0;
	serial_unit #(.FIFO_DEPTH(16)) dut (.sys_clk(sys_clk), .rst(rst),
		.operation_mode_reg(md), .bit_period(16'h0008),
		.tx_wr_valid(tx_wr_valid), .tx_buffer(tx_buffer),
		.tx_wr_ready(tx_wr_ready), .tx_status_reg(tx_status_reg),
		.tx_done(tx_done), .serial_tx_pin(serial_tx_pin),
		.serial_rx_pin(rx_line), .rx_result(rx_result),
		.rx_done(rx_done), .rx_err(rx_err));
	remote_node #(.BP(BP)) remote (.sys_clk(sys_clk),
		.line_in(serial_tx_pin), .line_out(rx_line));
	// gating lets the bench freeze the unit's clock mid-frame
	initial forever #2 if (clk_run) sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (tx_done === 1'h1) n_done <= n_done + 1;
	end
	always @(posedge sys_clk) if (cycles == 30000) begin
		err_total++;
		finish_test();
	end
	task finish_test();
		if (err_total == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	task check(input logic [15:0] seen, input logic [15:0] exp,
		input string msg);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %0t %s", $time, msg);
		end
	endtask : check
	task set_mode(input logic [7:0] v);
		@(posedge sys_clk);
		#1 md = v;
	endtask : set_mode
	task wr(input logic [7:0] d);
		int k;
		k = 0;
		@(posedge sys_clk);
		#1 tx_wr_valid = 1'h1;
		tx_buffer = d;
		while (tx_wr_ready !== 1'h1 && k < 3000) begin
			@(posedge sys_clk);
			#1 k++;
		end
		@(posedge sys_clk);
		#1 tx_wr_valid = 1'h0;
	endtask : wr
	task wait_got(input int n);
		int k;
		k = 0;
		while (remote.got_q.size() < n && k < 3000) begin
			@(posedge sys_clk);
			k++;
		end
	endtask : wait_got
	task wait_rx();
		int k;
		k = 0;
		while (rx_done !== 1'h1 && rx_err !== 1'h1 && k < 3000) begin
			@(posedge sys_clk);
			#1 k++;
		end
		seen_done = rx_done;
		seen_err = rx_err;
		@(posedge sys_clk);
		#1;
	endtask : wait_rx
	task clear_q();
		remote.got_q.delete();
		remote.start_q.delete();
	endtask : clear_q
	initial begin
		repeat (5) @(posedge sys_clk);
		#1 rst = 1'h0;
		check({serial_tx_pin, tx_wr_ready, tx_status_reg}, 16'h000c, "idle");
		set_mode(8'h84);
		set_mode(8'hc4);
		wr(8'ha5);
		wr(8'h3c);
		wait_got(2);
		check(remote.got_q[0], 16'h00a5, "tx byte 0");
		check(remote.got_q[1], 16'h003c, "tx byte");
		check(remote.start_q[1] - remote.start_q[0], 10 * BP + 2, "gap");
		repeat (4 * BP) @(posedge sys_clk);
		check(n_done, 16'h0002, "tx_done count");
		clear_q();
		set_mode(8'h84);
		set_mode(8'h86);
		set_mode(8'hc6);
		wr(8'h0f);
		wr(8'hf0);
		wait_got(2);
		check(remote.start_q[1] - remote.start_q[0], 11 * BP + 2, "gap2");
		set_mode(8'h84);
		set_mode(8'h84);
		for (int i = 0; i < 16; i++) wr(8'h10 + i[7:0]);
		check({tx_wr_ready, tx_status_reg}, 16'h0002, "full");
		// refused write while the buffer is full
		tx_wr_valid = 1'h1;
		tx_buffer = 8'hee;
		repeat (3) @(posedge sys_clk);
		#1 tx_wr_valid = 1'h0;
		clear_q();
		set_mode(8'hc4);
		wait_got(16);
		repeat (20 * BP) @(posedge sys_clk);
		check(remote.got_q.size(), 16'h0010, "drain count");
		for (int i = 0; i < 16; i++) check(remote.got_q[i], 16'h0010 + i, "order");
		check({tx_wr_ready, tx_status_reg}, 16'h0004, "drained");
		clear_q();
		set_mode(8'h84);
		wr(8'h77);
		wr(8'h78);
		set_mode(8'h00);
		set_mode(8'h84);
		set_mode(8'hc4);
		repeat (30 * BP) @(posedge sys_clk);
		check({remote.got_q.size(), serial_tx_pin}, 16'h0001, "flush");
		wr(8'h81);
		repeat (3 * BP) @(posedge sys_clk);
		#1 pin_hold = serial_tx_pin;
		st_hold = tx_status_reg;
		@(negedge sys_clk);
		clk_run = 1'h0;
		#200;
		check(serial_tx_pin, pin_hold, "pin frozen");
		check(tx_status_reg, st_hold, "regs frozen");
		check(st_hold, 16'h0001, "busy mid-frame");
		check(pin_hold, 16'h0000, "second data bit");
		clk_run = 1'h1;
		set_mode(8'h84);
		set_mode(8'h00);
		repeat (12 * BP) @(posedge sys_clk);
		clear_q();
		for (logic [2:0] p = 3'h0; p < 3'h4; p++) begin
			set_mode(8'h84);
			set_mode({3'h4, p[1:0], 3'h4});
			set_mode({3'h5, p[1:0], 3'h4});
			pb = (p == 3'h2) ? ~^(8'h31 + p) : ((p == 3'h3) ? ^(8'h31 + p) : 1'h0);
			fork
				remote.send_frame(8'h31 + p, p != 3'h0, pb);
			join_none
			wait_rx();
			check({seen_done, seen_err, rx_result}, {2'h2, 8'h31 + p, 2'h0},
				"rx par");
		end
		set_mode(8'h84);
		set_mode(8'h86);
		set_mode(8'ha6);
		fork
			begin
				remote.send_frame(8'hc3, 1'h0, 1'h0);
				remote.send_frame(8'h3c, 1'h0, 1'h0);
			end
		join_none
		wait_rx();
		check({seen_done, seen_err, rx_result}, {2'h2, 8'hc3, 2'h0},
			"rx a");
		wait_rx();
		check({seen_done, seen_err, rx_result}, {2'h2, 8'h3c, 2'h0},
			"rx b");
		for (int m = 0; m < 2; m++) begin
			set_mode(8'h84);
			set_mode({7'h4e, m[0]});
			set_mode({7'h5e, m[0]});
			fork
				remote.send_frame(8'h55, 1'h1, 1'h1);
			join_none
			wait_rx();
			check({seen_done, seen_err, rx_result}, {m[0], 1'h1, 10'h156},
				"err mode");
		end
		set_mode(8'h84);
		// length changed with both enables off
		set_mode(8'h80);
		set_mode(8'ha0);
		fork
			remote.send_frame(8'hd5, 1'h0, 1'h0);
		join_none
		wait_rx();
		check({seen_done, seen_err, rx_result}, {2'h2, 8'h55, 2'h0},
			"rx 7-bit");
		// eighth bit and stop must pass before the next frame
		repeat (2 * BP) @(posedge sys_clk);
		set_mode(8'h80);
		set_mode(8'h84);
		fork
			remote.send_frame(8'h69, 1'h0, 1'h0);
		join_none
		@(posedge sys_clk);
		set_mode(8'ha4);
		wait_rx();
		check({seen_done, seen_err, rx_result}, {2'h2, 8'h69, 2'h0},
			"low start");
		finish_test();
	end
endmodule : async_serial_unit_six_control_bench
